// >>> rtl/msi_fwd_defs.svh
// Constants of the upstream message interrupt forwarder
`ifndef MSI_FWD_DEFS_SVH
`define MSI_FWD_DEFS_SVH
`define MSI_ADDR_LO 32'hFEE00000
`define MSI_ADDR_HI 32'hFEEFFFFF
`define MSI_DEST_LSB 12
`define MSI_DEST_W 8
`define SRC_GFX 1'h0
`define SRC_HUB 1'h1
`define TRDY_DELAY 2'h2
`endif

// >>> rtl/msi_fwd_pkg.sv
// Types of the upstream message interrupt forwarder
package msi_fwd_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_MEMW,
		ST_PRIO,
		ST_REQ1,
		ST_REQ2,
		ST_RESP
	} fwd_state_e;
endpackage

// >>> rtl/upstream_msi_forwarder.sv
// Upstream message interrupt forwarder onto the processor bus
`timescale 1ns/100ps
`include "msi_fwd_defs.svh"
module upstream_msi_forwarder #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic up_wr_valid,
	input wire logic up_wr_src,
	input wire logic [AW-1:0] up_wr_addr,
	input wire logic [DW-1:0] up_wr_data,
	output logic up_wr_ready,
	output logic mem_wr_valid,
	output logic mem_wr_src,
	output logic [AW-1:0] mem_wr_addr,
	output logic [DW-1:0] mem_wr_data,
	input wire logic mem_wr_ready,
	input wire logic redirect_en,
	input wire logic [`MSI_DEST_W-1:0] redirect_dest,
	input wire logic intack_req,
	output logic intack_fwd,
	output logic priority_agent_bus_request_n,
	input wire logic bus_owner_released,
	input wire logic request_phase_strobe_n_in,
	output logic request_phase_strobe_n_out,
	output logic request_phase_strobe_n_oe_n,
	input wire logic bus_req_is_msg,
	output logic [AW-1:0] bus_addr_n_out,
	output logic bus_addr_n_oe_n,
	output logic [DW-1:0] bus_data_n_out,
	output logic bus_data_n_oe_n,
	output logic host_target_ready_n
);
	msi_fwd_pkg::fwd_state_e state_reg, state_next;
	logic [AW-1:0] addr_reg;
	logic [DW-1:0] data_reg;
	logic src_reg;
	logic intack_pend_reg;
	logic [1:0] trdy_cnt_reg;
	logic trdy_busy_reg;
	logic msg_seen_reg;
	logic [AW-1:0] addr_n_reg;
	logic [DW-1:0] data_n_reg;
	logic strobe_n_reg, prio_req_n_reg, addr_oe_n_reg, data_oe_n_reg, trdy_n_reg;
	logic intack_fwd_reg;

	wire in_range = (up_wr_addr >= `MSI_ADDR_LO) && (up_wr_addr <= `MSI_ADDR_HI);
	wire accept = up_wr_valid && up_wr_ready;
	wire [AW-1:0] redir_addr = redirect_en ?
		{up_wr_addr[AW-1:`MSI_DEST_LSB+`MSI_DEST_W], redirect_dest,
		up_wr_addr[`MSI_DEST_LSB-1:0]} : up_wr_addr;
	wire hub_pending = (state_reg != msi_fwd_pkg::ST_IDLE) && (src_reg == `SRC_HUB);
	wire intack_go = intack_pend_reg && !hub_pending && !up_wr_valid;
	wire own_strobe = state_reg == msi_fwd_pkg::ST_REQ1;
	// Any message cycle, own or other
	wire msg_cycle = own_strobe || (!request_phase_strobe_n_in && bus_req_is_msg);

	// One transfer at a time keeps arrival order per interface
	// Single transfer in flight
	assign up_wr_ready = (state_reg == msi_fwd_pkg::ST_IDLE) && !intack_go;
	assign mem_wr_valid = state_reg == msi_fwd_pkg::ST_MEMW;
	assign mem_wr_src = src_reg;
	assign mem_wr_addr = addr_reg;
	assign mem_wr_data = data_reg;
	assign intack_fwd = intack_fwd_reg;
	assign priority_agent_bus_request_n = prio_req_n_reg;
	assign request_phase_strobe_n_out = strobe_n_reg;
	assign request_phase_strobe_n_oe_n = strobe_n_reg;
	assign bus_addr_n_out = addr_n_reg;
	assign bus_addr_n_oe_n = addr_oe_n_reg;
	assign bus_data_n_out = data_n_reg;
	assign bus_data_n_oe_n = data_oe_n_reg;
	assign host_target_ready_n = trdy_n_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			msi_fwd_pkg::ST_IDLE: begin
				if (accept && !in_range) begin
					state_next = msi_fwd_pkg::ST_MEMW;
				end else if (accept) begin
					state_next = msi_fwd_pkg::ST_PRIO;
				end
			end
			msi_fwd_pkg::ST_MEMW: begin
				if (mem_wr_ready) begin
					state_next = msi_fwd_pkg::ST_IDLE;
				end
			end
			msi_fwd_pkg::ST_PRIO: begin
				if (bus_owner_released) begin
					state_next = msi_fwd_pkg::ST_REQ1;
				end
			end
			msi_fwd_pkg::ST_REQ1: state_next = msi_fwd_pkg::ST_REQ2;
			msi_fwd_pkg::ST_REQ2: state_next = msi_fwd_pkg::ST_RESP;
			msi_fwd_pkg::ST_RESP: begin
				if (!trdy_n_reg) begin
					state_next = msi_fwd_pkg::ST_IDLE;
				end
			end
			default: state_next = msi_fwd_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= msi_fwd_pkg::ST_IDLE;
			addr_reg <= '0;
			data_reg <= '0;
			src_reg <= 1'h0;
		end else begin
			state_reg <= state_next;
			if (accept) begin
				addr_reg <= in_range ? redir_addr : up_wr_addr;
				data_reg <= up_wr_data;
				src_reg <= up_wr_src;
			end
		end
	end

	// Request stays pending until the hub side is drained
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			intack_pend_reg <= 1'h0;
			intack_fwd_reg <= 1'h0;
		end else begin
			intack_pend_reg <= intack_req || (intack_pend_reg && !intack_go);
			intack_fwd_reg <= intack_go;
		end
	end

	// Strobe and address in first cycle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			prio_req_n_reg <= 1'h1;
			strobe_n_reg <= 1'h1;
			addr_oe_n_reg <= 1'h1;
			data_oe_n_reg <= 1'h1;
			addr_n_reg <= '0;
			data_n_reg <= '0;
		end else begin
			prio_req_n_reg <= !(state_next == msi_fwd_pkg::ST_PRIO ||
				state_next == msi_fwd_pkg::ST_REQ1 || state_next == msi_fwd_pkg::ST_REQ2);
			strobe_n_reg <= state_next != msi_fwd_pkg::ST_REQ1;
			addr_oe_n_reg <= !(state_next == msi_fwd_pkg::ST_REQ1 ||
				state_next == msi_fwd_pkg::ST_REQ2);
			data_oe_n_reg <= state_next != msi_fwd_pkg::ST_RESP;
			addr_n_reg <= ~addr_reg;
			data_n_reg <= ~data_reg;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			trdy_busy_reg <= 1'h0;
			trdy_cnt_reg <= 2'h0;
			trdy_n_reg <= 1'h1;
			msg_seen_reg <= 1'h0;
		end else begin
			msg_seen_reg <= msg_cycle;
			trdy_n_reg <= !(trdy_busy_reg && trdy_cnt_reg == `TRDY_DELAY);
			if (msg_cycle && !trdy_busy_reg) begin
				trdy_busy_reg <= 1'h1;
				trdy_cnt_reg <= 2'h0;
			end else if (trdy_busy_reg) begin
				trdy_cnt_reg <= trdy_cnt_reg + 2'h1;
				trdy_busy_reg <= trdy_cnt_reg != `TRDY_DELAY;
			end
		end
	end
	// Acknowledge, message delivery and the plain memory write path exist here

	property p_range_to_msg;
		@(posedge ref_clk) disable iff (!rstn)
		accept && in_range |=> state_reg == msi_fwd_pkg::ST_PRIO;
	endproperty
	a_range_to_msg: assert property (p_range_to_msg) else $error("range write not a message");
	property p_plain_to_mem;
		@(posedge ref_clk) disable iff (!rstn)
		accept && !in_range |=> mem_wr_valid && mem_wr_addr == $past(up_wr_addr);
	endproperty
	a_plain_to_mem: assert property (p_plain_to_mem) else $error("plain write lost");
	property p_no_msg_mem;
		@(posedge ref_clk) disable iff (!rstn)
		mem_wr_valid |-> !(mem_wr_addr >= `MSI_ADDR_LO && mem_wr_addr <= `MSI_ADDR_HI);
	endproperty
	a_no_msg_mem: assert property (p_no_msg_mem) else $error("message on memory path");
	property p_ads_first;
		@(posedge ref_clk) disable iff (!rstn)
		$fell(request_phase_strobe_n_out) |-> !bus_addr_n_oe_n && !priority_agent_bus_request_n
			##1 request_phase_strobe_n_out && !bus_addr_n_oe_n;
	endproperty
	a_ads_first: assert property (p_ads_first) else $error("strobe not one cycle");
	property p_priority_agent_bus_request_n_before;
		@(posedge ref_clk) disable iff (!rstn)
		$fell(request_phase_strobe_n_out) |-> !$past(priority_agent_bus_request_n);
	endproperty
	a_priority_agent_bus_request_n_before: assert property (p_priority_agent_bus_request_n_before) else $error("no priority request");
	property p_inverted;
		@(posedge ref_clk) disable iff (!rstn)
		!request_phase_strobe_n_out |-> bus_addr_n_out == ~addr_reg;
	endproperty
	a_inverted: assert property (p_inverted) else $error("address not inverted");
	property p_data;
		@(posedge ref_clk) disable iff (!rstn)
		!bus_data_n_oe_n |-> bus_data_n_out == ~data_reg;
	endproperty
	a_data: assert property (p_data) else $error("message data wrong");
	property p_trdy;
		@(posedge ref_clk) disable iff (!rstn)
		msg_cycle && !trdy_busy_reg |-> ##4 !host_target_ready_n;
	endproperty
	a_trdy: assert property (p_trdy) else $error("target ready missing");
	property p_intack;
		@(posedge ref_clk) disable iff (!rstn)
		intack_fwd |-> !$past(hub_pending);
	endproperty
	a_intack: assert property (p_intack) else $error("acknowledge before flush");
	property p_order;
		@(posedge ref_clk) disable iff (!rstn)
		mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && !up_wr_ready;
	endproperty
	a_order: assert property (p_order) else $error("write overtaken");
	property p_redir;
		@(posedge ref_clk) disable iff (!rstn)
		accept && in_range && redirect_en |=>
			addr_reg[`MSI_DEST_LSB+`MSI_DEST_W-1:`MSI_DEST_LSB] == $past(redirect_dest);
	endproperty
	a_redir: assert property (p_redir) else $error("redirect ignored");
	property p_hold;
		@(posedge ref_clk) disable iff (!rstn)
		!up_wr_ready && state_reg != msi_fwd_pkg::ST_IDLE |=> $stable(addr_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("held transfer changed");
	c_msg: cover property (@(posedge ref_clk) disable iff (!rstn) $fell(request_phase_strobe_n_out));
	c_mem: cover property (@(posedge ref_clk) disable iff (!rstn) mem_wr_valid && mem_wr_ready);
	c_ack: cover property (@(posedge ref_clk) disable iff (!rstn) intack_fwd);
endmodule

// >>> verification/msi_bus_partner.sv
// Stand-in for the bus owner and the memory write path
`timescale 1ns/100ps
module msi_bus_partner (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [3:0] lat,
	input wire logic priority_agent_bus_request_n,
	input wire logic mem_wr_valid,
	output logic bus_owner_released,
	output logic mem_wr_ready
);
	logic [3:0] bus_cnt_reg;
	logic [3:0] mem_cnt_reg;
	// Owner stops only after its latency, never ahead of the request
	assign bus_owner_released = !priority_agent_bus_request_n && bus_cnt_reg >= lat;
	assign mem_wr_ready = mem_wr_valid && mem_cnt_reg >= lat;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bus_cnt_reg <= 4'h0;
			mem_cnt_reg <= 4'h0;
		end else begin
			bus_cnt_reg <= priority_agent_bus_request_n ? 4'h0 : bus_cnt_reg + 4'h1;
			mem_cnt_reg <= (mem_wr_valid && !mem_wr_ready) ? mem_cnt_reg + 4'h1 : 4'h0;
		end
	end
endmodule

// >>> verification/upstream_msi_forwarder_bench.sv
// Self-checking bench of the message interrupt forwarder
`timescale 1ns/100ps
`include "msi_fwd_defs.svh"
module upstream_msi_forwarder_bench;
	logic ref_clk, rstn, up_wr_valid, up_wr_src, up_wr_ready, mem_wr_valid, mem_wr_src;
	logic mem_wr_ready, redirect_en, intack_req, intack_fwd, prio_req_n, owner_rel, strobe_out;
	logic strobe_oe_n, tb_strobe_n, tb_msg, addr_oe_n, data_oe_n, tgt_rdy_n;
	logic [31:0] up_wr_addr, up_wr_data, mem_wr_addr, mem_wr_data, addr_n, data_n, seed, a;
	logic [7:0] redirect_dest;
	logic [3:0] lat;
	int err_total, checks, pos;
	// Own strobe counts as a message on the shared wire
	wire strobe_wire = strobe_oe_n ? tb_strobe_n : strobe_out;
	wire msg_wire = strobe_oe_n ? tb_msg : 1'b1;
	upstream_msi_forwarder u_upstream_msi_forwarder (.ref_clk(ref_clk), .rstn(rstn),
		.up_wr_valid(up_wr_valid), .up_wr_src(up_wr_src), .up_wr_addr(up_wr_addr),
		.up_wr_data(up_wr_data), .up_wr_ready(up_wr_ready), .mem_wr_valid(mem_wr_valid),
		.mem_wr_src(mem_wr_src), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
		.mem_wr_ready(mem_wr_ready), .redirect_en(redirect_en), .redirect_dest(redirect_dest),
		.intack_req(intack_req), .intack_fwd(intack_fwd),
		.priority_agent_bus_request_n(prio_req_n),
		.bus_owner_released(owner_rel), .request_phase_strobe_n_in(strobe_wire),
		.request_phase_strobe_n_out(strobe_out), .request_phase_strobe_n_oe_n(strobe_oe_n),
		.bus_req_is_msg(msg_wire), .bus_addr_n_out(addr_n), .bus_addr_n_oe_n(addr_oe_n),
		.bus_data_n_out(data_n), .bus_data_n_oe_n(data_oe_n), .host_target_ready_n(tgt_rdy_n));
	msi_bus_partner u_msi_bus_partner (.ref_clk(ref_clk), .rstn(rstn), .lat(lat),
		.priority_agent_bus_request_n(prio_req_n), .mem_wr_valid(mem_wr_valid),
		.bus_owner_released(owner_rel), .mem_wr_ready(mem_wr_ready));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Bounded wait; a hang counts as a mismatch
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (up_wr_ready !== 1'b1 && n < 80);
		if (n >= 80) begin
			err_total++;
			close_out();
		end
	endtask
	task automatic drive_wr(input logic s, input logic [31:0] ad, input logic [31:0] d);
		@(posedge ref_clk);
		#1 up_wr_valid = 1'b1;
		up_wr_src = s;
		up_wr_addr = ad;
		up_wr_data = d;
		wait_ready();
		@(posedge ref_clk);
		#1 up_wr_valid = 1'b0;
	endtask
	task automatic run_wr(input logic s, input logic [31:0] ad, input logic [31:0] d);
		logic msg, fin;
		logic [31:0] ea;
		int n, ns, na, nt;
		msg = ad >= `MSI_ADDR_LO && ad <= `MSI_ADDR_HI;
		ea = ad;
		if (msg && redirect_en)
			ea[`MSI_DEST_LSB +: `MSI_DEST_W] = redirect_dest;
		drive_wr(s, ad, d);
		fin = 1'b0;
		ns = 0;
		na = 0;
		nt = 0;
		for (n = 0; n < 60 && !fin; n++) begin
			@(negedge ref_clk);
			if (msg) begin
				if (mem_wr_valid) chk("mem_valid", 32'h0, 32'h1);
				if (!strobe_out) ns++;
				if (!strobe_out) chk("msg_addr", ~ea, addr_n);
				if (!strobe_out) chk("prio_req_n", 32'h0, prio_req_n);
				if (!strobe_out) chk("strobe_oe_n", 32'h0, strobe_oe_n);
				if (!addr_oe_n) na++;
				if (!data_oe_n) chk("msg_data", ~d, data_n);
				if (!data_oe_n) chk("addr_released", 32'h1, addr_oe_n);
				if (!tgt_rdy_n) chk("own_tgt_rdy_delay", 32'h4, nt);
				if (ns > 0) nt++;
				fin = !tgt_rdy_n;
			end else begin
				if (!prio_req_n) chk("prio_req_n", 32'h1, prio_req_n);
				if (mem_wr_valid && mem_wr_ready) begin
					chk("mem_addr", ad, mem_wr_addr);
					chk("mem_data", d, mem_wr_data);
					chk("mem_src", s, mem_wr_src);
					fin = 1'b1;
				end
			end
		end
		if (msg) chk("strobes", 32'h1, ns);
		if (msg) chk("addr_cycles", 32'h2, na);
		if (!fin) begin
			err_total++;
			close_out();
		end
		wait_ready();
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		{rstn, up_wr_valid, up_wr_src, redirect_en, intack_req, tb_msg} = 6'h0;
		{up_wr_addr, up_wr_data, redirect_dest, lat} = 76'h0;
		{err_total, checks, tb_strobe_n, seed} = {64'h0, 1'b1, 32'h17AA3};
		repeat (12) @(posedge ref_clk);
		#1 rstn = 1'b1;
		// Range edges on both sources
		for (int i = 0; i < 8; i++) begin
			a = i[2] ? 32'hFEF00000 - i[1] : 32'hFEE00000 - !i[1];
			run_wr(i[0], a, xs());
		end
		for (int i = 0; i < 40; i++) begin
			@(posedge ref_clk);
			#1 lat = 4'(xs() & 32'h3);
			redirect_en = 1'(xs());
			redirect_dest = 8'(xs());
			a = xs();
			if (a[31]) a = {12'hFEE, a[19:0]};
			run_wr(a[30], a, xs());
		end
		// Reset in mid-message: every output back to its idle level
		lat = 4'h3;
		drive_wr(1'h0, 32'hFEE02000, xs());
		@(posedge ref_clk);
		#1 rstn = 1'h0;
		@(negedge ref_clk);
		chk("rst_ready", 32'h1, up_wr_ready);
		chk("rst_strobe", 32'h3, {strobe_out, strobe_oe_n});
		chk("rst_oe_n", 32'h3, {addr_oe_n, data_oe_n});
		chk("rst_prio_n", 32'h1, prio_req_n);
		chk("rst_tgt_rdy_n", 32'h1, tgt_rdy_n);
		chk("rst_pulses", 32'h0, {mem_wr_valid, intack_fwd});
		chk("rst_bus_val", 32'h0, addr_n | data_n);
		@(posedge ref_clk);
		#1 rstn = 1'h1;
		@(negedge ref_clk);
		chk("rel_ready", 32'h1, up_wr_ready);
		chk("rel_prio_n", 32'h1, prio_req_n);
		// Plain write stalled, then a message queued behind it
		lat = 4'h3;
		drive_wr(1'b1, 32'h00001000, xs());
		run_wr(1'b1, 32'hFEE01000, xs());
		// Acknowledge waits for the hub write to drain
		drive_wr(1'b1, 32'h00002000, xs());
		@(posedge ref_clk);
		#1 intack_req = 1'b1;
		@(posedge ref_clk);
		#1 intack_req = 1'b0;
		pos = 0;
		for (int n = 0; n < 40 && pos < 2; n++) begin
			@(negedge ref_clk);
			if (mem_wr_valid && mem_wr_ready) pos = 1;
			if (intack_fwd) chk("ack_flushed", 32'h1, pos);
			if (intack_fwd) pos = 2;
		end
		chk("ack_seen", 32'h2, pos);
		wait_ready();
		// Foreign request: message gets target ready 4 cycles on, other none
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk);
			#1 {tb_strobe_n, tb_msg} = {1'b0, k[0]};
			@(posedge ref_clk);
			#1 {tb_strobe_n, tb_msg} = 2'h2;
			pos = 0;
			for (int n = 1; n < 8; n++) begin
				@(negedge ref_clk);
				if (!tgt_rdy_n && pos == 0) pos = n;
			end
			chk("trdy_delay", k ? 32'h4 : 32'h0, pos);
		end
		close_out();
	end
endmodule
